// ==== logic/sccsel_ctrl.sv ====
// system clock select control register with axi4-lite slave
// Overview of operation
// - port select 1 turns sub-clock pins into the oscillator pair
// - stop bit 1 halts the main oscillator, 0 runs it
// - watchdog select 0 gives interrupt on timeout, 1 gives reset
// - once watchdog select is 1, software cannot clear it
// - source select 0 picks main oscillator, 1 picks sub-clock
// - stopping the main oscillator forces divide-by-8 clock division
// - sub-clock drive select goes to 1 on stop mode or reset
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module sccsel_ctrl (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // system events
  input wire logic stop_mode_entry,
  input wire logic wdog_timeout,
  // clock control outputs
  output logic subclk_osc_enable,
  output logic main_osc_enable,
  output logic sysclk_use_sub,
  output logic subclk_high_drive,
  output logic force_div8,
  output logic [2:0] main_div_forced,
  output logic wdog_irq,
  output logic wdog_reset_req
);
  logic [7:0] ctrl_q, ctrl_d;
  logic aw_q, aw_d, w_q, w_d, bv_q, bv_d, ar_q, ar_d, rv_q, rv_d;
  logic [31:0] awaddr_q, awaddr_d, wdata_q, wdata_d, rdata_q, rdata_d;
  logic wstrb0_q, wstrb0_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [7:0] out_q, out_d;
  logic [2:0] div_q, div_d;
  logic awrdy_q, awrdy_d, wrdy_q, wrdy_d;
  logic do_write;

  assign do_write = aw_q && w_q && !bv_q;

  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    bv_d = bv_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb0_d = wstrb0_q;
    bresp_d = bresp_q;
    ctrl_d = ctrl_q;
    if (s_axi_awvalid && !aw_q) begin
      aw_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_q) begin
      w_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb0_d = s_axi_wstrb[0];
    end
    if (do_write) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      bv_d = 1'b1;
      bresp_d = sccsel_pkg::RESP_OKAY;
      if (awaddr_q == sccsel_pkg::ADDR_CTRL0) begin
        if (wstrb0_q) begin
          ctrl_d = wdata_q[7:0];
          // sticky once set
          ctrl_d[sccsel_pkg::BIT_WDOG] = wdata_q[sccsel_pkg::BIT_WDOG] |
            ctrl_q[sccsel_pkg::BIT_WDOG];
        end
      end else if (awaddr_q != sccsel_pkg::ADDR_STATUS) begin
        bresp_d = sccsel_pkg::RESP_SLVERR;
      end
    end else if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end
    // hardware set wins over any software write in the same cycle
    if (stop_mode_entry) begin
      ctrl_d[sccsel_pkg::BIT_DRIVE] = 1'b1;
    end
    // ready copies live in their own flops so the bus sees no inverter
    awrdy_d = !aw_d;
    wrdy_d = !w_d;
  end

  always_comb begin
    ar_d = 1'b0;
    rv_d = rv_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end
    if (s_axi_arvalid && !rv_q && !ar_q) begin
      ar_d = 1'b1;
      rv_d = 1'b1;
      rresp_d = sccsel_pkg::RESP_OKAY;
      rdata_d = 32'h0000_0000;
      if (s_axi_araddr == sccsel_pkg::ADDR_CTRL0) begin
        rdata_d[7:0] = ctrl_q;
      end else if (s_axi_araddr == sccsel_pkg::ADDR_STATUS) begin
        rdata_d[7:0] = out_q;
      end else begin
        rresp_d = sccsel_pkg::RESP_SLVERR;
      end
    end
  end

  always_comb begin
    out_d = 8'h00;
    out_d[0] = ctrl_d[sccsel_pkg::BIT_PORT];
    out_d[1] = !ctrl_d[sccsel_pkg::BIT_STOP];
    out_d[2] = ctrl_d[sccsel_pkg::BIT_SRC];
    out_d[3] = ctrl_d[sccsel_pkg::BIT_DRIVE];
    out_d[4] = ctrl_d[sccsel_pkg::BIT_STOP];
    // watchdog outcome routed by the action select bit
    out_d[5] = wdog_timeout && !ctrl_d[sccsel_pkg::BIT_WDOG];
    out_d[6] = wdog_timeout && ctrl_d[sccsel_pkg::BIT_WDOG];
    // divide code gets its own flop so the output has no mux behind it
    div_d = ctrl_d[sccsel_pkg::BIT_STOP] ? sccsel_pkg::DIV_BY_8 :
      3'h0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= sccsel_pkg::CTRL0_RESET;
      aw_q <= 1'b0;
      w_q <= 1'b0;
      bv_q <= 1'b0;
      ar_q <= 1'b0;
      rv_q <= 1'b0;
      awaddr_q <= 32'h0000_0000;
      wdata_q <= 32'h0000_0000;
      wstrb0_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      bresp_q <= 2'h0;
      rresp_q <= 2'h0;
      out_q <= sccsel_pkg::OUTS_RESET;
      div_q <= 3'h0;
      awrdy_q <= 1'b1;
      wrdy_q <= 1'b1;
    end else begin
      ctrl_q <= ctrl_d;
      aw_q <= aw_d;
      w_q <= w_d;
      bv_q <= bv_d;
      ar_q <= ar_d;
      rv_q <= rv_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb0_q <= wstrb0_d;
      rdata_q <= rdata_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      out_q <= out_d;
      div_q <= div_d;
      awrdy_q <= awrdy_d;
      wrdy_q <= wrdy_d;
    end
  end

  assign s_axi_awready = awrdy_q;
  assign s_axi_wready = wrdy_q;
  assign s_axi_bvalid = bv_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ar_q;
  assign s_axi_rvalid = rv_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign subclk_osc_enable = out_q[0];
  assign main_osc_enable = out_q[1];
  assign sysclk_use_sub = out_q[2];
  assign subclk_high_drive = out_q[3];
  assign force_div8 = out_q[4];
  assign main_div_forced = div_q;
  assign wdog_irq = out_q[5];
  assign wdog_reset_req = out_q[6];

  chk_wdog_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
    ctrl_q[sccsel_pkg::BIT_WDOG] |=> ctrl_q[sccsel_pkg::BIT_WDOG])
    else $error("watchdog select cleared after set");
  chk_div8_forced: assert property (@(posedge aclk) disable iff (!aresetn)
    force_div8 == !main_osc_enable && main_div_forced ==
    (force_div8 ? sccsel_pkg::DIV_BY_8 : 3'h0))
    else $error("main stopped without divide-by-8");
  chk_stop_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 main_osc_enable == !$past(ctrl_d[sccsel_pkg::BIT_STOP]))
    else $error("main oscillator enable mismatch");
  chk_drive_stop: assert property (@(posedge aclk) disable iff (!aresetn)
    stop_mode_entry |=> ctrl_q[sccsel_pkg::BIT_DRIVE] &&
    subclk_high_drive)
    else $error("drive not raised on stop mode");
  chk_wdog_route: assert property (@(posedge aclk) disable iff (!aresetn)
    wdog_timeout && ctrl_q[sccsel_pkg::BIT_WDOG] |=> wdog_reset_req &&
    !wdog_irq)
    else $error("watchdog reset not routed");
  chk_wdog_irq: assert property (@(posedge aclk) disable iff (!aresetn)
    wdog_timeout && !ctrl_d[sccsel_pkg::BIT_WDOG] |=> wdog_irq)
    else $error("watchdog interrupt not routed");
  chk_port_sel: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 subclk_osc_enable == $past(ctrl_d[sccsel_pkg::BIT_PORT]))
    else $error("sub oscillator enable mismatch");
  chk_src_sel: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 sysclk_use_sub == $past(ctrl_d[sccsel_pkg::BIT_SRC]))
    else $error("clock source mismatch");
  cov_write: cover property (@(posedge aclk) s_axi_bvalid && s_axi_bready);
  cov_read: cover property (@(posedge aclk) s_axi_rvalid && s_axi_rready);
  cov_stop: cover property (@(posedge aclk) force_div8 && sysclk_use_sub);
  cov_wreset: cover property (@(posedge aclk) wdog_reset_req);
endmodule
`default_nettype wire

// ==== common/sccsel_pkg.sv ====
// package for the system clock select control block
package sccsel_pkg;
  localparam logic [31:0] ADDR_CTRL0 = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
  localparam int BIT_DRIVE = 3;
  localparam int BIT_PORT = 4;
  localparam int BIT_STOP = 5;
  localparam int BIT_WDOG = 6;
  localparam int BIT_SRC = 7;
  localparam logic [7:0] CTRL0_RESET = 8'h08;
  // status image of the reset register: main oscillator on, high drive
  localparam logic [7:0] OUTS_RESET = 8'h0a;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [2:0] DIV_BY_8 = 3'h3;
  typedef struct packed {
    logic sysclk_source_select;
    logic wdog_action_select;
    logic main_osc_stop;
    logic subclk_port_select;
    logic subclk_drive_select;
  } sccsel_ctrl_s;
endpackage

// ==== dv/tb_sccsel_ctrl.sv ====
// self-checking bench for the system clock select control block
`timescale 1ns/100ps
`default_nettype none
module tb_sccsel_ctrl;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
  logic [31:0] s_axi_araddr = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic stop_mode_entry = 1'h0, wdog_timeout = 1'h0;
  logic subclk_osc_enable, main_osc_enable, sysclk_use_sub, subclk_high_drive;
  logic force_div8, wdog_irq, wdog_reset_req;
  logic [2:0] main_div_forced;
  int fails = 0, total_checks = 0, cyc = 0;
  localparam logic [31:0] CTRL = sccsel_pkg::ADDR_CTRL0;
  localparam logic [1:0] OK = sccsel_pkg::RESP_OKAY;
  wire logic [7:0] outs = {subclk_osc_enable, main_osc_enable, sysclk_use_sub,
    subclk_high_drive, force_div8, main_div_forced};

  sccsel_ctrl i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .stop_mode_entry, .wdog_timeout, .subclk_osc_enable, .main_osc_enable,
    .sysclk_use_sub, .subclk_high_drive, .force_div8, .main_div_forced,
    .wdog_irq, .wdog_reset_req);

  always #2 aclk = ~aclk;

  task automatic test_done;
    if (fails == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // generous ceiling: the sequence needs well under 300 cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      test_done;
    end
  end

  task automatic chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [31:0] a, d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask

  task automatic rd(input logic [31:0] a, e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    chk("rdata", e, s_axi_rdata);
  endtask

  // outputs settle one edge after the write or event
  task automatic ck(input logic [7:0] e);
    @(posedge aclk);
    #1;
    chk("outs", {24'h0, e}, {24'h0, outs});
  endtask

  // one-cycle event pulse, then look at the watchdog outputs
  task automatic ev(input logic wd, st, input logic [1:0] e);
    @(posedge aclk);
    wdog_timeout <= wd;
    stop_mode_entry <= st;
    @(posedge aclk);
    wdog_timeout <= 1'h0;
    stop_mode_entry <= 1'h0;
    #1;
    chk("wdog", {30'h0, e}, {30'h0, wdog_irq, wdog_reset_req});
  endtask

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    rd(CTRL, {24'h0, sccsel_pkg::CTRL0_RESET}, OK);
    ck(8'h50);
    wr(CTRL, 32'h90, OK);
    ck(8'he0);
    wr(CTRL, 32'hb0, OK);
    ck({5'h15, sccsel_pkg::DIV_BY_8});
    rd(sccsel_pkg::ADDR_STATUS, 32'h15, OK);
    ev(1'h1, 1'h0, 2'h2);
    wr(CTRL, 32'hf0, OK);
    ev(1'h1, 1'h0, 2'h1);
    wr(CTRL, 32'h90, OK);
    rd(CTRL, 32'hd0, OK);
    ck(8'he0);
    ev(1'h0, 1'h1, 2'h0);
    rd(CTRL, 32'hd8, OK);
    wr(sccsel_pkg::ADDR_STATUS, 32'h0, OK);
    rd(CTRL, 32'hd8, OK);
    wr(32'h10, 32'hff, sccsel_pkg::RESP_SLVERR);
    rd(32'h10, 32'h0, sccsel_pkg::RESP_SLVERR);
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    rd(CTRL, 32'h08, OK);
    ck(8'h50);
    rd(sccsel_pkg::ADDR_STATUS, 32'h0a, OK);
    test_done;
  end
endmodule
`default_nettype wire
